// ### rsw_checker.sv
/* checker: concurrent assertions on the ports of rsw_sequencer.
   assumes one clock, sys_clk, and rst_n asynchronous active low. */
`timescale 1ns/1ns
`default_nettype none
module rsw_checker #(
    parameter int POWER_UP_DELAY_TIMER_CYCLES = 20
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // stimulus seen
    input wire logic reg_wr,
    input wire logic por_pulse,
    input wire logic supply_low,
    input wire logic wdt_timeout,
    input wire logic sleep_exec,
    // control outputs
    input wire logic core_reset,
    input wire logic core_run,
    input wire logic osc_driver_en,
    input wire logic wdt_clear,
    input wire logic watchdog_enable_bit,
    input wire logic low_voltage_detect_enable,
    // pins
    input wire logic [5:0] port_a_o,
    input wire logic [5:0] port_a_oe_n,
    input wire logic [5:0] port_b_o
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    int since_por;
    // cycles since the last power-on pulse (por_pulse only), saturating at 1000000
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) since_por <= 0;
        else if (por_pulse) since_por <= 0;
        else if (since_por < 1000000) since_por <= since_por + 1;
    end
    chk_por_reset: assert property (por_pulse |=> core_reset && !core_run)
        else $error("power-on pulse gave no reset");
    chk_supply_hold: assert property (
        supply_low && low_voltage_detect_enable && !$past(reg_wr) |=> core_reset)
        else $error("low supply gave no reset");
    chk_wdt_reset: assert property (
        wdt_timeout && watchdog_enable_bit && !$past(reg_wr) |=> core_reset)
        else $error("watchdog time-out gave no reset");
    chk_sleep_entry: assert property (
        sleep_exec && core_run && !por_pulse && !wdt_timeout && !supply_low
        |=> !osc_driver_en && !core_run && wdt_clear)
        else $error("sleep entry outputs wrong");
    chk_pins_frozen: assert property (
        !osc_driver_en && !$past(osc_driver_en) && !core_reset
        |-> $stable(port_a_o) && $stable(port_a_oe_n) && $stable(port_b_o))
        else $error("pins moved during sleep");
    chk_wake_hold: assert property ($rose(osc_driver_en) && !core_reset |-> !core_run [*8])
        else $error("execution resumed without delay");
    chk_reset_no_run: assert property (core_reset |-> !core_run)
        else $error("core runs while reset held");
    chk_release_delay: assert property ($fell(core_reset) |-> since_por >= POWER_UP_DELAY_TIMER_CYCLES)
        else $error("reset released before power-up delay");
    cover property (sleep_exec && core_run);
    cover property ($rose(osc_driver_en) && !core_reset);
    cover property (wdt_timeout && watchdog_enable_bit && !osc_driver_en);
endmodule
bind rsw_sequencer rsw_checker #(.POWER_UP_DELAY_TIMER_CYCLES(POWER_UP_DELAY_TIMER_CYCLES)) u_chk (
    .sys_clk(sys_clk), .rst_n(rst_n), .reg_wr(reg_wr), .por_pulse(por_pulse),
    .supply_low(supply_low), .wdt_timeout(wdt_timeout), .sleep_exec(sleep_exec),
    .core_reset(core_reset), .core_run(core_run), .osc_driver_en(osc_driver_en),
    .wdt_clear(wdt_clear), .watchdog_enable_bit(watchdog_enable_bit),
    .low_voltage_detect_enable(low_voltage_detect_enable), .port_a_o(port_a_o),
    .port_a_oe_n(port_a_oe_n), .port_b_o(port_b_o)
);
`default_nettype wire

// ### rsw_pkg.sv
/*
 * Package for the reset, sleep and wake sequencer: register offsets,
 * reset values, field positions, state codes and timing counts.
 * Assumes a 100 MHz system clock and an 8-bit register port.
 */
package rsw_pkg;

    // register offsets on the 8-bit register port
    localparam logic [7:0] OFS_PC_LOW = 8'h02;
    localparam logic [7:0] OFS_CORE_STATUS = 8'h03;
    localparam logic [7:0] OFS_INDIRECT = 8'h04;
    localparam logic [7:0] OFS_DIR_A = 8'h05;
    localparam logic [7:0] OFS_DIR_B = 8'h06;
    localparam logic [7:0] OFS_CHIP_CONTROL = 8'h07;
    localparam logic [7:0] OFS_WAKE_ENABLE = 8'h0b;
    localparam logic [7:0] OFS_CARRIER_PERIOD = 8'h0c;
    localparam logic [7:0] OFS_CARRIER_HIGH = 8'h0d;
    localparam logic [7:0] OFS_KEY_CODE = 8'h0e;
    localparam logic [7:0] OFS_OPTION = 8'h10;

    // reset values
    localparam logic [7:0] RST_OPTION = 8'h3f;
    localparam logic [7:0] RST_DIR = 8'h3f;
    localparam logic [7:0] RST_PC_LOW = 8'hff;
    localparam logic [7:0] RST_WAKE_ENABLE = 8'h00;
    localparam logic [7:0] RST_CARRIER_PERIOD = 8'h0c;
    localparam logic [7:0] RST_CARRIER_HIGH = 8'h06;
    localparam logic [7:0] RST_KEY_CODE = 8'hff;
    localparam logic [1:0] RST_INDIRECT_TOP = 2'h3;
    localparam logic [7:0] RST_CHIP_CONTROL = 8'he0;
    localparam logic [2:0] RST_STATUS_TOP = 3'h0;

    // field positions
    localparam int STAT_TIMEOUT_BIT = 4;
    localparam int STAT_POWER_DOWN_BIT = 3;
    localparam int CC_WATCHDOG_ENABLE_BIT = 7;
    localparam int CC_LOW_VOLTAGE_ENABLE_BIT = 6;
    localparam int WAKE_ENABLE_MSB = 5;
    localparam int PORT_W = 6;

    // timing
    localparam int CLK_FREQ_KHZ = 100000;
    localparam int POWER_UP_DELAY_MS = 20;
    localparam int POWER_UP_DELAY_CYCLES = POWER_UP_DELAY_MS * CLK_FREQ_KHZ;
    localparam int POWER_UP_DELAY_TIMER_W = 21;
    localparam logic [7:0] OSC_STARTUP_COUNT = 8'h80;

    typedef enum logic [6:0] {
        ST_RESET = 7'h01,
        ST_POWER_UP_DELAY_TIMER = 7'h02,
        ST_OST = 7'h04,
        ST_RUN = 7'h08,
        ST_SLEEP = 7'h10,
        ST_WAKE_POWER_UP_DELAY_TIMER = 7'h20,
        ST_WAKE_OST = 7'h40
    } rsw_state_e;

endpackage

// ### rsw_sequencer.sv
/*
 * Reset, sleep and wake sequencer of a small remote-control controller.
 * Holds the core in reset through the power-up delay and oscillator
 * start-up count after a reset, enters and leaves power-down, keeps the cause flags
 * and loads register reset values.
 * Assumes every input except rst_n is synchronous to sys_clk; the core reports the
 * sleep and watchdog-clear instructions and port-B accesses as pulses.
 */
`timescale 1ns/1ns
`default_nettype none

module rsw_sequencer
    import rsw_pkg::*;
#(
    parameter int POWER_UP_DELAY_TIMER_CYCLES = POWER_UP_DELAY_CYCLES
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // reset sources
    input wire logic por_pulse,
    input wire logic supply_low,
    input wire logic wdt_timeout,
    // oscillator input
    input wire logic osc_input_pin,
    input wire logic osc_swing_ok,
    // core events
    input wire logic sleep_exec,
    input wire logic clrwdt_exec,
    input wire logic second_io_port_access,
    input wire logic key_press,
    input wire logic key_scan_auto,
    input wire logic [7:0] key_value,
    // pins
    input wire logic [PORT_W-1:0] second_io_port_in,
    input wire logic [PORT_W-1:0] port_a_latch,
    input wire logic [PORT_W-1:0] port_b_latch,
    output logic [PORT_W-1:0] port_a_o,
    output logic [PORT_W-1:0] port_a_oe_n,
    output logic [PORT_W-1:0] port_b_o,
    output logic [PORT_W-1:0] port_b_oe_n,
    // core control
    output logic core_reset,
    output logic core_run,
    output logic osc_driver_en,
    output logic wdt_clear,
    output logic watchdog_enable_bit,
    output logic low_voltage_detect_enable,
    // reset-loaded values for the core
    output logic [7:0] option_value,
    output logic [7:0] pc_low_byte,
    output logic [7:0] indirect_pointer,
    output logic [7:0] carrier_period,
    output logic [7:0] carrier_high_time
);

    function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
        hit = (addr == ofs);
    endfunction

    rsw_state_e state_reg;
    rsw_state_e state_next;
    logic [POWER_UP_DELAY_TIMER_W-1:0] power_up_delay_timer_cnt_reg;
    logic [7:0] ost_cnt_reg;
    logic osc_prev_reg;
    logic [7:0] status_reg;
    logic [7:0] chip_control_reg;
    logic [7:0] wake_enable_reg;
    logic [7:0] dir_a_reg;
    logic [7:0] dir_b_reg;
    logic [7:0] key_code_reg;
    logic [PORT_W-1:0] change_ref_reg;

    // event decode
    wire wdt_en = chip_control_reg[CC_WATCHDOG_ENABLE_BIT];
    wire lvd_en = chip_control_reg[CC_LOW_VOLTAGE_ENABLE_BIT];
    wire wdt_fire = wdt_timeout & wdt_en;
    wire brownout = supply_low & lvd_en;
    wire power_event = por_pulse | brownout;
    wire reset_event = power_event | wdt_fire;
    wire in_reset = state_reg == ST_RESET;
    wire in_run = state_reg == ST_RUN;
    wire in_sleep = state_reg == ST_SLEEP;
    wire do_sleep = in_run & sleep_exec & ~reset_event;
    wire osc_edge = osc_input_pin & ~osc_prev_reg & osc_swing_ok;
    wire power_up_delay_timer_done = power_up_delay_timer_cnt_reg == POWER_UP_DELAY_TIMER_W'(POWER_UP_DELAY_TIMER_CYCLES - 1);
    wire ost_done = ost_cnt_reg == OSC_STARTUP_COUNT - 8'h01;
    wire [PORT_W-1:0] change_bits = second_io_port_in ^ change_ref_reg;
    wire [PORT_W-1:0] change_armed = wake_enable_reg[WAKE_ENABLE_MSB:0]
                                     & dir_b_reg[PORT_W-1:0];
    wire change_wake = |(change_bits & change_armed);
    wire key_wake = key_press & key_scan_auto;
    wire any_wake = change_wake | key_wake;
    wire in_delay = state_reg == ST_POWER_UP_DELAY_TIMER || state_reg == ST_WAKE_POWER_UP_DELAY_TIMER;
    wire in_count = state_reg == ST_OST || state_reg == ST_WAKE_OST;

    // register port decode
    wire wr_status = reg_wr & hit(reg_addr, OFS_CORE_STATUS);
    wire wr_chip = reg_wr & hit(reg_addr, OFS_CHIP_CONTROL);
    wire wr_wake = reg_wr & hit(reg_addr, OFS_WAKE_ENABLE);
    wire wr_dir_a = reg_wr & hit(reg_addr, OFS_DIR_A);
    wire wr_dir_b = reg_wr & hit(reg_addr, OFS_DIR_B);
    wire wr_option = reg_wr & hit(reg_addr, OFS_OPTION);
    wire wr_pcl = reg_wr & hit(reg_addr, OFS_PC_LOW);
    wire wr_fsr = reg_wr & hit(reg_addr, OFS_INDIRECT);
    wire wr_period = reg_wr & hit(reg_addr, OFS_CARRIER_PERIOD);
    wire wr_high = reg_wr & hit(reg_addr, OFS_CARRIER_HIGH);
    wire [7:0] rd_mux =
        hit(reg_addr, OFS_CORE_STATUS) ? status_reg :
        hit(reg_addr, OFS_CHIP_CONTROL) ? chip_control_reg :
        hit(reg_addr, OFS_WAKE_ENABLE) ? wake_enable_reg :
        hit(reg_addr, OFS_PC_LOW) ? pc_low_byte :
        hit(reg_addr, OFS_INDIRECT) ? indirect_pointer :
        hit(reg_addr, OFS_CARRIER_PERIOD) ? carrier_period :
        hit(reg_addr, OFS_CARRIER_HIGH) ? carrier_high_time :
        hit(reg_addr, OFS_KEY_CODE) ? key_code_reg : 8'h00;

    // sequencer
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_RESET: begin
                if (!reset_event) begin
                    state_next = ST_POWER_UP_DELAY_TIMER;
                end
            end
            ST_POWER_UP_DELAY_TIMER: begin
                if (power_up_delay_timer_done) begin
                    state_next = ST_OST;
                end
            end
            ST_OST: begin
                if (osc_edge && ost_done) begin
                    state_next = ST_RUN;
                end
            end
            ST_RUN: begin
                if (do_sleep) begin
                    state_next = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (any_wake) begin
                    state_next = ST_WAKE_POWER_UP_DELAY_TIMER;
                end
            end
            ST_WAKE_POWER_UP_DELAY_TIMER: begin
                if (power_up_delay_timer_done) begin
                    state_next = ST_WAKE_OST;
                end
            end
            ST_WAKE_OST: begin
                if (osc_edge && ost_done) begin
                    state_next = ST_RUN;
                end
            end
            default: begin
                state_next = ST_RESET;
            end
        endcase
        if (reset_event) begin
            state_next = ST_RESET;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_RESET;
            core_reset <= 1'b1;
            core_run <= 1'b0;
            osc_driver_en <= 1'b1;
        end else begin
            state_reg <= state_next;
            core_reset <= state_next == ST_RESET || state_next == ST_POWER_UP_DELAY_TIMER
                          || state_next == ST_OST;
            core_run <= state_next == ST_RUN;
            osc_driver_en <= state_next != ST_SLEEP;
        end
    end

    // power-up delay and oscillator start-up counters
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            power_up_delay_timer_cnt_reg <= '0;
            ost_cnt_reg <= 8'h00;
            osc_prev_reg <= 1'b0;
        end else begin
            osc_prev_reg <= osc_input_pin;
            if (in_delay && !power_up_delay_timer_done) begin
                power_up_delay_timer_cnt_reg <= power_up_delay_timer_cnt_reg + POWER_UP_DELAY_TIMER_W'(1);
            end else if (!in_delay) begin
                power_up_delay_timer_cnt_reg <= '0;
            end
            if (in_count && osc_edge) begin
                ost_cnt_reg <= ost_cnt_reg + 8'h01;
            end else if (!in_count) begin
                ost_cnt_reg <= 8'h00;
            end
        end
    end

    // status flags and watchdog clear
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            status_reg <= {RST_STATUS_TOP, 1'b1, 1'b1, 3'h0};
            wdt_clear <= 1'b0;
        end else begin
            wdt_clear <= do_sleep | (in_run & clrwdt_exec);
            if (reset_event) begin
                status_reg[7:5] <= RST_STATUS_TOP;
                if (power_event) begin
                    status_reg[STAT_TIMEOUT_BIT] <= 1'b1;
                    status_reg[STAT_POWER_DOWN_BIT] <= 1'b1;
                end else begin
                    status_reg[STAT_TIMEOUT_BIT] <= 1'b0;
                end
            end else if (in_reset) begin
                status_reg[7:5] <= RST_STATUS_TOP;
            end else begin
                if (wr_status) begin
                    status_reg[7:5] <= reg_wdata[7:5];
                    status_reg[2:0] <= reg_wdata[2:0];
                end
                if (do_sleep) begin
                    status_reg[STAT_TIMEOUT_BIT] <= 1'b1;
                    status_reg[STAT_POWER_DOWN_BIT] <= 1'b0;
                end else if (in_run && clrwdt_exec) begin
                    status_reg[STAT_TIMEOUT_BIT] <= 1'b1;
                    status_reg[STAT_POWER_DOWN_BIT] <= 1'b1;
                end
            end
        end
    end

    // software registers with reset values
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            chip_control_reg <= RST_CHIP_CONTROL;
            wake_enable_reg <= RST_WAKE_ENABLE;
            dir_a_reg <= RST_DIR;
            dir_b_reg <= RST_DIR;
            option_value <= RST_OPTION;
            pc_low_byte <= RST_PC_LOW;
            indirect_pointer <= {RST_INDIRECT_TOP, 6'h00};
            carrier_period <= RST_CARRIER_PERIOD;
            carrier_high_time <= RST_CARRIER_HIGH;
            key_code_reg <= RST_KEY_CODE;
        end else if (in_reset || reset_event) begin
            chip_control_reg <= RST_CHIP_CONTROL;
            wake_enable_reg <= RST_WAKE_ENABLE;
            dir_a_reg <= RST_DIR;
            dir_b_reg <= RST_DIR;
            option_value <= RST_OPTION;
            pc_low_byte <= RST_PC_LOW;
            indirect_pointer[7:6] <= RST_INDIRECT_TOP;
            carrier_period <= RST_CARRIER_PERIOD;
            carrier_high_time <= RST_CARRIER_HIGH;
            key_code_reg <= RST_KEY_CODE;
        end else begin
            if (wr_chip) begin
                chip_control_reg <= reg_wdata;
            end
            if (wr_wake) begin
                wake_enable_reg <= {2'h0, reg_wdata[WAKE_ENABLE_MSB:0]};
            end
            if (wr_dir_a) begin
                dir_a_reg <= {2'h0, reg_wdata[PORT_W-1:0]};
            end
            if (wr_dir_b) begin
                dir_b_reg <= {2'h0, reg_wdata[PORT_W-1:0]};
            end
            if (wr_option) begin
                option_value <= {2'h0, reg_wdata[5:0]};
            end
            if (wr_pcl) begin
                pc_low_byte <= reg_wdata;
            end
            if (wr_fsr) begin
                indirect_pointer <= reg_wdata;
            end
            if (wr_period) begin
                carrier_period <= reg_wdata;
            end
            if (wr_high) begin
                carrier_high_time <= reg_wdata;
            end
            if (key_wake || (in_run && key_press)) begin
                key_code_reg <= key_value;
            end
        end
    end

    // change reference, pins and register read
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            change_ref_reg <= '0;
            port_a_o <= '0;
            port_b_o <= '0;
            port_a_oe_n <= '1;
            port_b_oe_n <= '1;
            reg_rdata <= 8'h00;
            watchdog_enable_bit <= 1'b1;
            low_voltage_detect_enable <= 1'b1;
        end else begin
            if (in_run && second_io_port_access) begin
                change_ref_reg <= second_io_port_in;
            end
            if (!in_sleep && state_next != ST_SLEEP) begin
                port_a_o <= port_a_latch;
                port_b_o <= port_b_latch;
                port_a_oe_n <= dir_a_reg[PORT_W-1:0];
                port_b_oe_n <= {1'b1, dir_b_reg[PORT_W-2:0]};
            end
            reg_rdata <= reg_rd ? rd_mux : 8'h00;
            watchdog_enable_bit <= wdt_en;
            low_voltage_detect_enable <= lvd_en;
        end
    end

endmodule

`default_nettype wire

// ### tb_top.sv
/* testbench: reset, sleep and wake cases for rsw_sequencer, checked
   against a bench model. assumes rsw_checker is bound alongside. */
`timescale 1ns/1ns
`default_nettype none
module tb_top
    import rsw_pkg::*;
;
    localparam int POWER_UP_DELAY_TIMER_C = 20;
    localparam int MIN_WAIT = POWER_UP_DELAY_TIMER_C + 4 * 126;
    logic sys_clk, rst_n, reg_wr, reg_rd, osc_input_pin, osc_swing_ok, key_scan_auto;
    logic sleep_exec, clrwdt_exec, second_io_port_access, core_reset, core_run;
    logic osc_driver_en, wdt_clear, rst_seen;
    logic [3:0] ev;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, key_value, pc_low_byte, carrier_high_time;
    logic [7:0] lfsr_reg, v;
    logic [7:0] osc_cnt = 8'h00;
    logic [PORT_W-1:0] second_io_port_in, port_a_latch, port_b_latch;
    logic [PORT_W-1:0] port_a_o, port_a_oe_n, port_b_oe_n;
    int errors = 0;
    int total_checks = 0;
    int cyc = 0;
    int n;
    int mdl[16];
    int regs_q[$] = '{2, 3, 7, 11, 12, 13, 14};
    int rst_q[$] = '{8'hff, 0, 8'he0, 0, 8'h0c, 8'h06, 8'hff};

    // ev: key press, watchdog time-out, power-on pulse, low supply
    rsw_sequencer #(.POWER_UP_DELAY_TIMER_CYCLES(POWER_UP_DELAY_TIMER_C)) u_dut (
        .sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .por_pulse(ev[2]), .supply_low(ev[3]), .wdt_timeout(ev[1]), .osc_input_pin,
        .osc_swing_ok, .sleep_exec, .clrwdt_exec, .second_io_port_access,
        .key_press(ev[0]), .key_scan_auto, .key_value, .second_io_port_in,
        .port_a_latch, .port_b_latch, .port_a_o, .port_a_oe_n, .port_b_o(),
        .port_b_oe_n, .core_reset, .core_run, .osc_driver_en, .wdt_clear,
        .watchdog_enable_bit(), .low_voltage_detect_enable(), .option_value(),
        .pc_low_byte, .indirect_pointer(), .carrier_period(), .carrier_high_time
    );

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // oscillator input: one rising edge every four clocks
    always @(posedge sys_clk) begin
        osc_cnt <= osc_cnt + 8'h01;
        osc_input_pin <= osc_cnt[1];
        if (core_reset === 1'b1) rst_seen <= 1'b1;
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors++;
            conclude();
        end
    end

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    task automatic conclude();
        $display("checks %0d, errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic idle(input int c);
        repeat (c) @(posedge sys_clk);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        if (a == 8'h07 || a == 8'h0b || a == 8'h0c || a == 8'h0d) mdl[a] = d;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask

    // load reset values and the expected cause flags into the model
    task automatic reset_regs(input int to, input int pd);
        foreach (regs_q[i]) mdl[regs_q[i]] = rst_q[i];
        mdl[3] = to * 16 + pd * 8;
        foreach (regs_q[i]) begin
            rd(8'(regs_q[i]));
            check(v, 8'(mdl[regs_q[i]]));
        end
        check(pc_low_byte, 8'hff);
    endtask

    task automatic wait_run(input int lo);
        n = 0;
        while (core_run !== 1'b1 && n < 3000) begin
            @(posedge sys_clk);
            #1 n++;
        end
        check(8'(core_run === 1'b1 && n >= lo), 8'h01);
    endtask

    task automatic hit(input int k, input int c);
        ev[k] <= 1'b1;
        idle(c);
        ev[k] <= 1'b0;
    endtask

    task automatic go_sleep();
        @(posedge sys_clk);
        second_io_port_access <= 1'b1;
        rst_seen <= 1'b0;
        @(posedge sys_clk);
        second_io_port_access <= 1'b0;
        sleep_exec <= 1'b1;
        @(posedge sys_clk);
        sleep_exec <= 1'b0;
        #1 check({5'h0, core_run, osc_driver_en, wdt_clear}, 8'h01);
    endtask

    initial begin
        {reg_addr, reg_wdata, key_value, reg_wr, reg_rd, ev} = '0;
        {osc_swing_ok, sleep_exec, clrwdt_exec, second_io_port_access, key_scan_auto} = '0;
        {second_io_port_in, port_a_latch, port_b_latch} = '0;
        rst_n = 1'b0;
        rst_seen = 1'b0;
        lfsr_reg = 8'h2d;
        repeat (16) @(posedge sys_clk);
        rst_n <= 1'b1;
        idle(300);
        check({6'h0, core_reset, core_run}, 8'h02);
        osc_swing_ok <= 1'b1;
        wait_run(4 * 126);
        reset_regs(1, 1);
        rd(8'h20);
        check(v, 8'h00);
        for (int i = 0; i < 4; i++) begin
            lfsr_reg = lfsr(lfsr_reg);
            key_value <= lfsr_reg;
            port_b_latch <= lfsr_reg[5:0];
            wr(8'h0c, lfsr_reg);
            wr(8'h0d, lfsr_reg ^ 8'h5a);
            rd(8'h0c);
            check(v, 8'(mdl[12]));
            check(carrier_high_time, 8'(mdl[13]));
        end
        // pin 1 drives, pin 2 has wake disabled, pin 0 may wake
        wr(8'h05, 8'h15);
        wr(8'h06, 8'h1d);
        wr(8'h0b, 8'h03);
        check({2'h0, port_b_oe_n}, 8'h3d);
        port_a_latch <= 6'h2a;
        go_sleep();
        rd(8'h03);
        check(v, 8'h10);
        port_a_latch <= 6'h15;
        second_io_port_in <= 6'h06;
        idle(50);
        check({1'b0, osc_driver_en, port_a_o}, 8'h2a);
        check({2'h0, port_a_oe_n}, 8'h15);
        second_io_port_in <= 6'h07;
        wait_run(MIN_WAIT);
        rd(8'h03);
        check({rst_seen, v[6:0]}, 8'h10);
        go_sleep();
        hit(0, 2);
        idle(50);
        check({7'h0, osc_driver_en}, 8'h00);
        key_scan_auto <= 1'b1;
        hit(0, 2);
        wait_run(MIN_WAIT);
        wr(8'h07, 8'h20);
        go_sleep();
        hit(1, 1);
        idle(50);
        check({6'h0, rst_seen, osc_driver_en}, 8'h00);
        hit(0, 2);
        wait_run(MIN_WAIT);
        wr(8'h07, 8'he0);
        wr(8'h0c, 8'h33);
        // watchdog clear in run sets both cause flags again
        @(posedge sys_clk);
        clrwdt_exec <= 1'b1;
        @(posedge sys_clk);
        clrwdt_exec <= 1'b0;
        rd(8'h03);
        check(v, 8'h18);
        hit(1, 1);
        wait_run(MIN_WAIT);
        reset_regs(0, 1);
        go_sleep();
        hit(1, 1);
        check({7'h0, core_reset}, 8'h01);
        wait_run(MIN_WAIT);
        reset_regs(0, 0);
        for (int k = 2; k < 4; k++) begin
            hit(k, 100);
            wait_run(MIN_WAIT);
            reset_regs(1, 1);
        end
        conclude();
    end
endmodule
`default_nettype wire
